// ==== hw/burst_sram_pkg.sv ====
// package: constants and carrier types for the pipelined burst sram access block
package burst_sram_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int DEPTH = 65536;
  localparam int BURST_W = 2;
  // sleep entry and exit both take two clock cycles
  localparam int SLEEP_ENTRY_CYCLES = 2;
  localparam int SLEEP_RECOVERY_CYCLES = 2;
  localparam logic [1:0] SLEEP_CNT_RST = 2'h0;
  localparam logic [1:0] BURST_RST = 2'h0;
  localparam logic [31:0] DATA_RST = 32'h0;
  localparam logic [15:0] ADDR_RST = 16'h0;

  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_READ,
    ACC_WRITE,
    ACC_PEND_WRITE
  } access_t;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_ENTERING,
    PWR_SLEEP,
    PWR_LEAVING
  } power_t;

  // registered synchronous bus inputs
  typedef struct packed {
    logic processor_addr_strobe_n;
    logic controller_addr_strobe_n;
    logic burst_step_n;
    logic global_write_n;
    logic byte_write_en_n;
    logic [3:0] lane_write_select_n;
    logic chip_sel_one_n;
    logic chip_sel_two;
    logic chip_sel_three_n;
    logic [15:0] addr;
    logic [31:0] wdata;
  } bus_in_t;

  // one entry of the read data buffer
  typedef struct packed {
    logic [31:0] data;
  } rd_word_t;
endpackage : burst_sram_pkg

// ==== hw/burst_sram_access.sv ====
// file: pipelined burst sram access logic with storage array
`timescale 1ns/1ps

// Operation
// - all sync inputs registered on rising edge; read data from output register
// - burst order chosen from the sampled order-select level
// - low two address bits load a wraparound two-bit burst counter at access start
// - global write low writes all four lanes, overriding byte controls
// - read starts on strobe with chips selected and writes high; processor strobe needs chip one
// - read data launched from output register next edge, driven only while output enable low
// - first cycle after leaving deselect keeps outputs high impedance
// - deselect by chip selects with a strobe turns outputs off one edge after it is decoded
// - processor strobe write takes two cycles: address first, data second
// - processor strobe first cycle ignores write controls and step, always a read
// - second cycle: global write stores whole word, else byte controls decide
// - byte write updates only selected lanes; others keep contents
// - data drivers off whenever a write cycle is detected
// - controller strobe write completes in one cycle, ignoring step
// - step input low during burst advances the burst counter
// - interleaved order is start xor step count
// - linear order adds step count modulo four
// - sleep input enters low-power state in two cycles; exit also two
// - access pending at sleep entry may be dropped
// - both strobes low with chip one selected: only processor strobe acts
// - order select low gives linear, high gives interleaved; static
// - lane n gates byte n of data; write needs byte enable and lane select low
// - strobes and step high hold current burst address
module burst_sram_access (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // synchronous bus controls
  input wire logic i_processor_addr_strobe_n,
  input wire logic i_controller_addr_strobe_n,
  input wire logic i_burst_step_n,
  input wire logic i_global_write_n,
  input wire logic i_byte_write_en_n,
  input wire logic [3:0] i_lane_write_select_n,
  input wire logic i_chip_sel_one_n,
  input wire logic i_chip_sel_two,
  input wire logic i_chip_sel_three_n,
  input wire logic [15:0] i_addr,
  // asynchronous pins
  input wire logic i_output_en_n,
  input wire logic i_sleep_request,
  input wire logic i_burst_order_interleaved,
  // shared data pins
  input wire logic [31:0] i_dq,
  output logic [31:0] o_dq,
  output logic o_dq_oe,
  // status
  output logic o_sleeping
);

  // ==========================================================
  // input registers and pin synchronisers
  // ==========================================================
  burst_sram_pkg::bus_in_t bus_q;
  burst_sram_pkg::bus_in_t bus_d;
  logic [1:0] sleep_sync_q;
  logic [1:0] order_sync_q;
  logic [1:0] oe_sync_q;

  assign bus_d = '{
    processor_addr_strobe_n: i_processor_addr_strobe_n,
    controller_addr_strobe_n: i_controller_addr_strobe_n,
    burst_step_n: i_burst_step_n,
    global_write_n: i_global_write_n,
    byte_write_en_n: i_byte_write_en_n,
    lane_write_select_n: i_lane_write_select_n,
    chip_sel_one_n: i_chip_sel_one_n,
    chip_sel_two: i_chip_sel_two,
    chip_sel_three_n: i_chip_sel_three_n,
    addr: i_addr,
    wdata: i_dq
  };

  // inputs come from the pins, so reset to idle (strobes and selects off)
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      bus_q <= '{
        processor_addr_strobe_n: 1'b1,
        controller_addr_strobe_n: 1'b1,
        burst_step_n: 1'b1,
        global_write_n: 1'b1,
        byte_write_en_n: 1'b1,
        lane_write_select_n: 4'hf,
        chip_sel_one_n: 1'b1,
        chip_sel_two: 1'b0,
        chip_sel_three_n: 1'b1,
        addr: burst_sram_pkg::ADDR_RST,
        wdata: burst_sram_pkg::DATA_RST
      };
    end else begin
      bus_q <= bus_d;
    end
  end

  // pins from outside the clock domain pass two flops; only the second one is read
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      sleep_sync_q <= 2'h0;
      order_sync_q <= 2'h3;
      oe_sync_q <= 2'h3;
    end else begin
      sleep_sync_q <= {sleep_sync_q[0], i_sleep_request};
      order_sync_q <= {order_sync_q[0], i_burst_order_interleaved};
      oe_sync_q <= {oe_sync_q[0], i_output_en_n};
    end
  end

  wire sleep_level = sleep_sync_q[1];
  wire interleaved = order_sync_q[1];
  wire oe_n_level = oe_sync_q[1];

  // ==========================================================
  // power state
  // ==========================================================
  burst_sram_pkg::power_t pwr_q;
  burst_sram_pkg::power_t pwr_d;
  logic [1:0] pwr_cnt_q;
  logic [1:0] pwr_cnt_d;
  // the counter runs only while entering or leaving sleep
  wire pwr_cnt_done = (pwr_cnt_q == 2'(burst_sram_pkg::SLEEP_ENTRY_CYCLES - 1));
  wire pwr_rec_done = (pwr_cnt_q == 2'(burst_sram_pkg::SLEEP_RECOVERY_CYCLES - 1));

  always_comb begin
    pwr_d = pwr_q;
    pwr_cnt_d = burst_sram_pkg::SLEEP_CNT_RST;
    case (pwr_q)
      burst_sram_pkg::PWR_RUN: begin
        if (sleep_level) begin
          pwr_d = burst_sram_pkg::PWR_ENTERING;
        end
      end
      burst_sram_pkg::PWR_ENTERING: begin
        pwr_cnt_d = 2'(pwr_cnt_q + 2'h1);
        if (pwr_cnt_done) begin
          pwr_d = burst_sram_pkg::PWR_SLEEP;
        end
      end
      burst_sram_pkg::PWR_SLEEP: begin
        if (!sleep_level) begin
          pwr_d = burst_sram_pkg::PWR_LEAVING;
        end
      end
      burst_sram_pkg::PWR_LEAVING: begin
        pwr_cnt_d = 2'(pwr_cnt_q + 2'h1);
        if (pwr_rec_done) begin
          pwr_d = burst_sram_pkg::PWR_RUN;
        end
      end
      default: pwr_d = burst_sram_pkg::PWR_RUN;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pwr_q <= burst_sram_pkg::PWR_RUN;
      pwr_cnt_q <= burst_sram_pkg::SLEEP_CNT_RST;
    end else begin
      pwr_q <= pwr_d;
      pwr_cnt_q <= pwr_cnt_d;
    end
  end

  // accesses are taken only in the run state
  wire running = (pwr_q == burst_sram_pkg::PWR_RUN);
  assign o_sleeping = (pwr_q == burst_sram_pkg::PWR_SLEEP);

  // ==========================================================
  // access decode on the registered inputs
  // ==========================================================
  // decode works on registered inputs, one edge after the pins are taken
  wire chips_on = !bus_q.chip_sel_one_n && bus_q.chip_sel_two && !bus_q.chip_sel_three_n;
  // processor strobe counts only while chip one is selected
  wire psel = !bus_q.processor_addr_strobe_n && !bus_q.chip_sel_one_n;
  // controller strobe counts only when processor strobe is not taken
  wire csel = !bus_q.controller_addr_strobe_n && !psel;
  wire any_strobe = psel || csel;
  wire lanes_on = !bus_q.byte_write_en_n && (bus_q.lane_write_select_n != 4'hf);
  wire wr_req = !bus_q.global_write_n || lanes_on;
  // byte lanes chosen by the lane selects, only while the byte write enable is low
  wire [3:0] byte_lanes = bus_q.byte_write_en_n ? 4'h0 : ~bus_q.lane_write_select_n;
  // global write wins over every byte control
  wire [3:0] lane_mask = !bus_q.global_write_n ? 4'hf : byte_lanes;

  // processor strobe start is always a read, write controls ignored
  wire start_read = running && chips_on && (psel || (csel && !wr_req));
  wire start_cwrite = running && chips_on && csel && wr_req;
  wire deselect = running && any_strobe && !chips_on;
  wire cont = running && !any_strobe;
  // with both strobes high the step input alone moves the burst
  wire step = cont && !bus_q.burst_step_n;

  // ==========================================================
  // access state and burst counter
  // ==========================================================
  burst_sram_pkg::access_t acc_q;
  burst_sram_pkg::access_t acc_d;
  logic [15:0] addr_q;
  // start_q keeps the first low address bits; cnt_q counts steps from it
  logic [1:0] start_q;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic first_q;

  always_comb begin
    acc_d = acc_q;
    if (!running) begin
      // a pending access is dropped on sleep entry
      acc_d = burst_sram_pkg::ACC_IDLE;
    end else if (deselect) begin
      acc_d = burst_sram_pkg::ACC_IDLE;
    end else if (start_read) begin
      acc_d = burst_sram_pkg::ACC_READ;
    end else if (start_cwrite) begin
      acc_d = burst_sram_pkg::ACC_WRITE;
    end else if (cont && acc_q != burst_sram_pkg::ACC_IDLE) begin
      // write controls on a following cycle turn a burst into a write
      acc_d = wr_req ? burst_sram_pkg::ACC_WRITE : burst_sram_pkg::ACC_READ;
    end
  end

  always_comb begin
    cnt_d = cnt_q;
    if (start_read || start_cwrite) begin
      cnt_d = burst_sram_pkg::BURST_RST;
    end else if (step && acc_q != burst_sram_pkg::ACC_IDLE) begin
      cnt_d = 2'(cnt_q + 2'h1);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      acc_q <= burst_sram_pkg::ACC_IDLE;
      addr_q <= burst_sram_pkg::ADDR_RST;
      start_q <= burst_sram_pkg::BURST_RST;
      cnt_q <= burst_sram_pkg::BURST_RST;
    end else begin
      acc_q <= acc_d;
      cnt_q <= cnt_d;
      if (start_read || start_cwrite) begin
        addr_q <= bus_q.addr;
        start_q <= bus_q.addr[1:0];
      end
    end
  end

  // burst address: xor for interleaved, add for linear
  wire [1:0] cnt_next = 2'(cnt_q + 2'h1);
  wire [1:0] burst_lo = interleaved ? (start_q ^ cnt_q) : 2'(start_q + cnt_q);
  // a step uses the next word in the same cycle, so the step reads or writes it at once
  wire [1:0] burst_lo_next = interleaved ? (start_q ^ cnt_next) : 2'(start_q + cnt_next);
  wire [1:0] start_lo = bus_q.addr[1:0];
  wire [1:0] cont_lo = step ? burst_lo_next : burst_lo;
  wire [15:0] cur_addr = (start_read || start_cwrite) ? {bus_q.addr[15:2], start_lo}
                       : {addr_q[15:2], cont_lo};

  // ==========================================================
  // storage array
  // ==========================================================
  logic [31:0] mem [burst_sram_pkg::DEPTH];
  wire do_write = start_cwrite || (cont && acc_q != burst_sram_pkg::ACC_IDLE && wr_req);
  wire do_read = start_read || (cont && acc_q != burst_sram_pkg::ACC_IDLE && !wr_req);

  // only selected lanes change
  always_ff @(posedge i_core_clk) begin
    for (int i = 0; i < burst_sram_pkg::LANES; i++) begin
      if (do_write && lane_mask[i]) begin
        mem[cur_addr][i*8 +: 8] <= bus_q.wdata[i*8 +: 8];
      end
    end
  end

  // ==========================================================
  // read buffer and output drive
  // ==========================================================
  burst_sram_pkg::rd_word_t buf_q [2];
  logic [1:0] buf_vld_q;
  logic rd_wr_q;
  wire buf_in_valid = do_read;
  wire buf_in_ready = !buf_vld_q[1]; // second slot free; pins always drain
  wire buf_out_ready = 1'b1;
  logic [31:0] dout_q;
  logic drive_q;
  logic sel_prev_q;

  // new word lands in slot 0 and is drained from there next; the previous word moves to slot 1
  // the pins never stall, so slot 1 only fills if the drain is ever gated
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      buf_vld_q <= 2'h0;
      dout_q <= burst_sram_pkg::DATA_RST;
    end else begin
      buf_vld_q <= {buf_vld_q[0] && !buf_out_ready, buf_in_valid && buf_in_ready};
      if (buf_in_valid && buf_in_ready) begin
        buf_q[0].data <= mem[cur_addr];
      end
      if (buf_vld_q[0]) begin
        buf_q[1] <= buf_q[0];
      end
      if (buf_vld_q[0] && buf_out_ready) begin
        dout_q <= buf_q[0].data;
      end
    end
  end

  // first-access masking is registered with drive_q, one cycle ahead of the output data
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      first_q <= 1'b0;
      sel_prev_q <= 1'b0;
      rd_wr_q <= 1'b0;
      drive_q <= 1'b0;
    end else begin
      sel_prev_q <= (acc_d != burst_sram_pkg::ACC_IDLE);
      first_q <= start_read && !sel_prev_q;
      rd_wr_q <= do_write;
      drive_q <= do_read && buf_in_ready;
    end
  end

  // ==========================================================
  // pin drive enable
  // ==========================================================
  assign o_dq = dout_q;
  // write cycles mask the drivers whatever output enable says
  wire write_mask = rd_wr_q || do_write;
  // first drive cycle after leaving deselect stays off, one cycle before the read word reaches o_dq
  wire first_mask = first_q;
  // deselect or sleep leaves the access idle and turns the drivers off
  wire access_live = (acc_q != burst_sram_pkg::ACC_IDLE) && running;
  assign o_dq_oe = drive_q && !first_mask && !write_mask && access_live && !oe_n_level;

endmodule : burst_sram_access

// ==== tb/burst_sram_access_asserts.sv ====
// checker: port-level properties of the burst sram access block
`timescale 1ns/1ps
module burst_sram_access_asserts (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // watched inputs
  input wire logic i_processor_addr_strobe_n,
  input wire logic i_controller_addr_strobe_n,
  input wire logic i_global_write_n,
  input wire logic i_chip_sel_one_n,
  input wire logic i_chip_sel_two,
  input wire logic i_chip_sel_three_n,
  input wire logic i_output_en_n,
  input wire logic i_sleep_request,
  // watched outputs
  input wire logic o_dq_oe,
  input wire logic o_sleeping
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);
  // ==========================================
  // decode of the sampled controls
  wire sel = !i_chip_sel_one_n && i_chip_sel_two && !i_chip_sel_three_n;
  wire desel = !i_controller_addr_strobe_n && i_chip_sel_one_n;
  wire cwr = !i_controller_addr_strobe_n && i_processor_addr_strobe_n && sel && !i_global_write_n;
  wire rd = (!i_processor_addr_strobe_n || !i_controller_addr_strobe_n) && sel && i_global_write_n;
  // ==========================================
  // properties
  chk_write_off: assert property (cwr |-> ##[1:2] !o_dq_oe)
    else $error("drivers on during write");
  chk_desel_off: assert property (desel |-> ##[1:2] !o_dq_oe)
    else $error("drivers on after deselect");
  chk_first_masked: assert property (desel ##1 rd |-> ##1 !o_dq_oe [*2])
    else $error("first read after deselect driven");
  chk_oe_gate: assert property (i_output_en_n [*4] |=> !o_dq_oe)
    else $error("drivers on while output enable high");
  chk_sleep_enter: assert property (i_sleep_request [*8] |=> o_sleeping)
    else $error("sleep not entered");
  chk_sleep_exit: assert property (!i_sleep_request [*8] |=> !o_sleeping)
    else $error("sleep not left");
  chk_sleep_quiet: assert property (o_sleeping |-> !o_dq_oe)
    else $error("drivers on in sleep");
  chk_sleep_cause: assert property ($rose(o_sleeping) |-> $past(i_sleep_request, 2))
    else $error("sleep without request");
  cover property ($rose(o_sleeping));
  cover property (o_dq_oe);
  cover property (cwr);
endmodule : burst_sram_access_asserts

// ==== tb/burst_sram_bus_model.sv ====
// partner: shared data lines seen from the external controller
`timescale 1ns/1ps
module burst_sram_bus_model (
  // clock
  input wire logic i_core_clk,
  // controller side
  input wire logic i_drive,
  input wire logic [31:0] i_wdata,
  // device side
  input wire logic [31:0] i_dev_dq,
  input wire logic i_dev_oe,
  // resolved lines
  output logic [31:0] o_bus
);
  logic [31:0] last_q = 32'h0;
  // controller drives only once the device has let go; released lines flip
  assign o_bus = i_dev_oe ? i_dev_dq : (i_drive ? i_wdata : ~last_q);
  always_ff @(posedge i_core_clk) last_q <= o_bus;
endmodule : burst_sram_bus_model

// ==== tb/pipelined_burst_sram_access_tb_top.sv ====
// bench: random and corner accesses against a reference memory
`timescale 1ns/1ps
module pipelined_burst_sram_access_tb_top;
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic p_n = 1'b1, c_n = 1'b1, s_n = 1'b1, g_n = 1'b1, b_n = 1'b1, cs1_n = 1'b1, oe_n = 1'b1;
  logic slp = 1'b0, ord = 1'b1, drv = 1'b0;
  logic [3:0] l_n = 4'hf;
  logic [15:0] a = 16'h0, ad;
  logic [31:0] wd = 32'h0, bus, o_dq;
  logic o_dq_oe, o_sleeping;
  logic [31:0] ref_m [0:255];
  int n_mismatch = 0, n_checks = 0, seed = 75661;
  always #2.5 i_core_clk = ~i_core_clk;
  burst_sram_access uut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_processor_addr_strobe_n(p_n),
    .i_controller_addr_strobe_n(c_n), .i_burst_step_n(s_n), .i_global_write_n(g_n), .i_byte_write_en_n(b_n),
    .i_lane_write_select_n(l_n), .i_chip_sel_one_n(cs1_n), .i_chip_sel_two(1'b1), .i_chip_sel_three_n(1'b0),
    .i_addr(a), .i_output_en_n(oe_n), .i_sleep_request(slp), .i_burst_order_interleaved(ord), .i_dq(bus),
    .o_dq(o_dq), .o_dq_oe(o_dq_oe), .o_sleeping(o_sleeping));
  burst_sram_bus_model far (.i_core_clk(i_core_clk), .i_drive(drv), .i_wdata(wd), .i_dev_dq(o_dq),
    .i_dev_oe(o_dq_oe), .o_bus(bus));
  // ==========================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic cyc(input logic p, c, s, g, input logic [3:0] l, input logic c1, input logic [15:0] x,
                     input logic [31:0] d);
    {p_n, c_n, s_n, g_n, l_n, cs1_n, a, wd} = {p, c, s, g, l, c1, x, d};
    b_n = &l;
    @(posedge i_core_clk);
    #1;
  endtask : cyc
  task automatic idle(input int n, input logic c1 = 1'b0);
    repeat (n) cyc(1, 1, 1, 1, 4'hf, c1, 16'h0, 32'h0);
  endtask : idle
  task automatic desel();
    cyc(1, 0, 1, 1, 4'hf, 1, 16'h0, 32'h0);
  endtask : desel
  task automatic wr(input logic pw, input logic [15:0] x, input logic [31:0] d, input logic g,
                    input logic [3:0] l);
    if (pw) cyc(0, 1, 0, g, l, 0, x, 32'h0);
    drv = 1;
    cyc(1, pw, pw, g, l, 0, x, d);
    drv = 0;
    desel();
    for (int i = 0; i < 4; i++) if (!g || !l[i]) ref_m[x[7:0]][8*i+:8] = d[8*i+:8];
  endtask : wr
  task automatic rd(input logic pr, input logic [15:0] x, input logic [31:0] exp);
    cyc(!pr, pr, 1, 1, 4'hf, 0, x, 32'h0);
    idle(4);
    chk(o_dq, exp);
    chk({31'h0, o_dq_oe}, 32'h1);
  endtask : rd
  task automatic stp(input logic [31:0] exp);
    cyc(1, 1, 0, 1, 4'hf, 0, 16'h0, 32'h0);
    idle(4);
    chk(o_dq, exp);
  endtask : stp
  task automatic wait_slp(input logic v);
    for (int i = 0; i < 20 && o_sleeping !== v; i++) idle(1, 1);
    if (o_sleeping !== v) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask : wait_slp
  function automatic logic [1:0] bnext(input logic [1:0] st, k, input logic il);
    return il ? st ^ k : st + k;
  endfunction : bnext
  // ==========================================
  // main sequence
  initial begin
    repeat (3) @(posedge i_core_clk);
    #1 i_sys_rst = 0;
    chk({30'h0, o_dq_oe, o_sleeping}, 32'h0);
    idle(2, 1);
    for (int i = 0; i < 24; i++) begin
      ad = {8'h0, 8'($random(seed))};
      oe_n = 1;
      idle(3);
      wr(0, ad, 32'($random(seed)), 0, 4'hf);
      wr(i[0], ad, 32'($random(seed)), i > 19, i[3:0]);
      oe_n = 0;
      idle(3);
      rd(i[1], ad, ref_m[ad[7:0]]);
    end
    oe_n = 1;
    idle(3);
    for (int k = 0; k < 4; k++) wr(0, {14'h3c, k[1:0]}, 32'hb0b0_0000 + k, 0, 4'hf);
    for (int o = 0; o < 2; o++) for (int st = 0; st < 4; st++) begin
      ord = o[0];
      oe_n = 0;
      idle(4);
      rd(st[1], {14'h3c, st[1:0]}, ref_m[{6'h3c, st[1:0]}]);
      for (int k = 1; k < 4; k++) stp(ref_m[{6'h3c, bnext(st[1:0], k[1:0], o[0])}]);
    end
    oe_n = 1;
    idle(3);
    wr(0, 16'h0010, 32'h1234_5678, 0, 4'hf);
    cyc(0, 0, 1, 0, 4'h0, 0, 16'h0010, 32'hdead_beef);
    idle(1);
    desel();
    oe_n = 0;
    idle(3);
    rd(1, 16'h0010, ref_m[16]);
    cyc(0, 1, 1, 1, 4'hf, 1, 16'h00f0, 32'h0);
    idle(4);
    chk(o_dq, ref_m[16]);
    desel();
    slp = 1;
    wait_slp(1);
    idle(6, 1);
    slp = 0;
    wait_slp(0);
    idle(3, 1);
    desel();
    rd(0, 16'h0010, ref_m[16]);
    report_and_stop();
  end
endmodule : pipelined_burst_sram_access_tb_top
bind burst_sram_access burst_sram_access_asserts chk_i (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
  .i_processor_addr_strobe_n(i_processor_addr_strobe_n), .i_controller_addr_strobe_n(i_controller_addr_strobe_n),
  .i_global_write_n(i_global_write_n), .i_chip_sel_one_n(i_chip_sel_one_n), .i_chip_sel_two(i_chip_sel_two),
  .i_chip_sel_three_n(i_chip_sel_three_n), .i_output_en_n(i_output_en_n), .i_sleep_request(i_sleep_request),
  .o_dq_oe(o_dq_oe), .o_sleeping(o_sleeping));
